// ==== supervisor_map.svh ====
// offsets, field positions, reset values and timing counts of the supervisor
`ifndef SUPERVISOR_MAP_SVH
`define SUPERVISOR_MAP_SVH

// system clock rate
`define CLK_FREQ_MHZ        50
// reset delay per channel, typical figure, in microseconds and cycles
`define RESET_DELAY_US      23500
`define RESET_DELAY_CYC     (`RESET_DELAY_US * `CLK_FREQ_MHZ)
// window upper boundary, in microseconds and cycles
`define WIN_UPPER_US        20000
`define WIN_UPPER_CYC       (`WIN_UPPER_US * `CLK_FREQ_MHZ)
// window lower boundary, in nanoseconds and cycles
`define WIN_LOWER_NS        1250000
`define WIN_LOWER_CYC       (`WIN_LOWER_NS * `CLK_FREQ_MHZ / 1000)
// fault pulse is the upper boundary divided by this
`define FAULT_PULSE_DIV     8
`define FAULT_PULSE_CYC     (`WIN_UPPER_CYC / `FAULT_PULSE_DIV)
// longest undervoltage to reset delay, in microseconds and cycles
`define UV_ASSERT_MAX_US    30
`define UV_ASSERT_MAX_CYC   (`UV_ASSERT_MAX_US * `CLK_FREQ_MHZ)
// timer width
`define CNT_W               24

// register byte offsets
`define ADDR_CTRL           4'h0
`define ADDR_STATUS         4'h4
`define ADDR_FAULTS         4'h8
// control register fields and reset value
`define CTRL_WD_OFF_BIT     0
`define CTRL_RESET          1'b0
// status register fields
`define ST_RESET_OUT_FIRST_BIT         0
`define ST_RESET_OUT_SECOND_BIT         1
`define ST_FAULT_BIT        2
`define ST_WD_RUN_BIT       3
`define ST_CH2_EN_BIT       4
`define ST_MODE_LSB         5
`define ST_PINS_LSB         7
// axi responses
`define RESP_OKAY           2'b00
`define RESP_SLVERR         2'b10

// synchroniser bit positions
`define SY_RAIL1            0
`define SY_RAIL2            1
`define SY_KICK             2
`define SY_WDOFF            3
`define SY_CFG_LSB          4
`define SY_PIN_LSB          6
`define SY_W                9
// edges after reset before the filtered pins can be trusted
`define SY_FILL_CYC         3'd4
// three-state select codes as seen on seq_select_in
`define SEL_TIED_HIGH       2'b01
`define SEL_TIED_LOW        2'b10

`endif

// ==== supervisor_pkg.sv ====
// types shared by the supervisor design
package supervisor_pkg;
`include "supervisor_map.svh"

	// start sequence chosen by the three-state select
	typedef enum logic [1:0] {
		MODE_FLOAT = 2'b00,
		MODE_HIGH  = 2'b01,
		MODE_LOW   = 2'b10
	} seq_mode_t;

	// whole state of the supervisor
	typedef struct packed {
		logic [`SY_W-1:0]  sync1;
		logic [`SY_W-1:0]  sync2;
		logic [`SY_W-1:0]  sync3;
		logic [`SY_W-1:0]  stable;
		logic              kick_prev;
		logic              reset_out_first_on;
		logic              reset_out_second_on;
		logic [`CNT_W-1:0] por1_cnt;
		logic [`CNT_W-1:0] por2_cnt;
		logic              ch2_en;
		logic [2:0]        warm_cnt;  // edges since reset while the filter fills
		logic              wd_run;
		logic [`CNT_W-1:0] wd_cnt;
		logic              fault_on;
		logic [`CNT_W-1:0] fault_cnt;
		logic [7:0]        fault_total;
		logic              wd_off;
		logic              aw_full;
		logic [3:0]        aw_addr;
		logic              w_full;
		logic [31:0]       w_data;
		logic [3:0]        w_strb;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              rvalid;
		logic [31:0]       rdata;
		logic [1:0]        rresp;
	} sup_state_t;
endpackage

// ==== supervisor_reset_watchdog.sv ====
// supervisor: two power-on resets, window watchdog and axi4-lite registers
`timescale 1ns/1ps
`include "supervisor_map.svh"

// Operation
// - decode three-state select into three sequences
// - high or low: second channel waits first rail
// - high: own-rail resets, watchdog after both released
// - low: both resets wait both rails, timer one
// - floating: channels start together, own-rail resets
// - floating: watchdog starts when first reset releases
// - rail ten percent low pulls reset low
// - rail good starts timer, release after delay
// - resets are active low open drain
// - disable input high stops the watchdog
// - kick edge before lower boundary is fault
// - no kick edge within upper boundary is fault
// - fault pulse lasts one eighth upper boundary
// - fault ends at timer expiry or reset low
// - upper boundary typically twenty milliseconds
// - lower boundary typically one point twenty-five milliseconds
// - reset asserts within thirty microseconds of undervoltage
module supervisor_reset_watchdog
	import supervisor_pkg::*;
#(
	parameter int RESET_DELAY_FIRST  = `RESET_DELAY_CYC,
	parameter int RESET_DELAY_SECOND = `RESET_DELAY_CYC,
	parameter int WIN_UPPER          = `WIN_UPPER_CYC,
	parameter int WIN_LOWER          = `WIN_LOWER_CYC,
	parameter int FAULT_PULSE        = `FAULT_PULSE_CYC
) (
	input  wire logic        clk_in,
	input  wire logic        resetn_in,
	input  wire logic        rail_sense_first_in,
	input  wire logic        rail_sense_second_in,
	input  wire logic [1:0]  seq_select_in,
	input  wire logic        watchdog_kick_in,
	input  wire logic        watchdog_disable_in,
	input  wire logic        reset_out_first_in,
	output logic             reset_out_first_out,
	output logic             reset_out_first_oen_out,
	input  wire logic        reset_out_second_in,
	output logic             reset_out_second_out,
	output logic             reset_out_second_oen_out,
	input  wire logic        watchdog_fault_in,
	output logic             watchdog_fault_out,
	output logic             watchdog_fault_oen_out,
	output logic             channel_second_enable_out,
	input  wire logic [3:0]  axi_awaddr_in,
	input  wire logic        axi_awvalid_in,
	output logic             axi_awready_out,
	input  wire logic [31:0] axi_wdata_in,
	input  wire logic [3:0]  axi_wstrb_in,
	input  wire logic        axi_wvalid_in,
	output logic             axi_wready_out,
	output logic [1:0]       axi_bresp_out,
	output logic             axi_bvalid_out,
	input  wire logic        axi_bready_in,
	input  wire logic [3:0]  axi_araddr_in,
	input  wire logic        axi_arvalid_in,
	output logic             axi_arready_out,
	output logic [31:0]      axi_rdata_out,
	output logic [1:0]       axi_rresp_out,
	output logic             axi_rvalid_out,
	input  wire logic        axi_rready_in
);

	// counts narrowed once to the timer width
	localparam logic [`CNT_W-1:0] DELAY1_C = `CNT_W'(RESET_DELAY_FIRST);
	localparam logic [`CNT_W-1:0] DELAY2_C = `CNT_W'(RESET_DELAY_SECOND);
	localparam logic [`CNT_W-1:0] UPPER_C  = `CNT_W'(WIN_UPPER);
	localparam logic [`CNT_W-1:0] LOWER_C  = `CNT_W'(WIN_LOWER);
	localparam logic [`CNT_W-1:0] PULSE_C  = `CNT_W'(FAULT_PULSE);
	localparam logic [`CNT_W-1:0] ONE_C    = `CNT_W'(1);

	sup_state_t s_reg;      // registered state
	sup_state_t s_next;     // next state
	seq_mode_t  mode;       // decoded sequence
	logic       rail1_ok;   // first rail above threshold, filtered
	logic       rail2_ok;   // second rail above threshold, filtered
	logic       kick_lvl;   // filtered kick level
	logic       good1;      // release condition of the first reset timer
	logic       good2;      // release condition of the second reset timer
	logic       wd_start;   // watchdog may run in this sequence
	logic       wd_block;   // watchdog held off by pin or software
	logic       kick_fall;  // one falling edge of the kick input
	logic       fault_hit;  // window violated this cycle
	logic       aw_hit;     // write address taken
	logic       w_hit;      // write data taken
	logic       ar_hit;     // read address taken
	logic [31:0] status_w;  // assembled status word

	// handshake outputs: a channel is ready while its holding slot is empty
	assign axi_awready_out = ~s_reg.aw_full;
	assign axi_wready_out  = ~s_reg.w_full;
	assign axi_arready_out = ~s_reg.rvalid;
	assign aw_hit          = axi_awvalid_in & ~s_reg.aw_full;
	assign w_hit           = axi_wvalid_in & ~s_reg.w_full;
	assign ar_hit          = axi_arvalid_in & ~s_reg.rvalid;

	// response outputs straight from flops
	assign axi_bvalid_out = s_reg.bvalid;
	assign axi_bresp_out  = s_reg.bresp;
	assign axi_rvalid_out = s_reg.rvalid;
	assign axi_rdata_out  = s_reg.rdata;
	assign axi_rresp_out  = s_reg.rresp;

	// open-drain pins only ever pull low; enable low means pulling
	assign reset_out_first_out      = 1'b0;
	assign reset_out_first_oen_out  = ~s_reg.reset_out_first_on;
	assign reset_out_second_out     = 1'b0;
	assign reset_out_second_oen_out = ~s_reg.reset_out_second_on;
	assign watchdog_fault_out       = 1'b0;
	assign watchdog_fault_oen_out   = ~s_reg.fault_on;
	assign channel_second_enable_out = s_reg.ch2_en;

	// filtered levels; the first sync stage feeds only the second
	assign rail1_ok = s_reg.stable[`SY_RAIL1];
	assign rail2_ok = s_reg.stable[`SY_RAIL2];
	assign kick_lvl = s_reg.stable[`SY_KICK];

	// three-state select decode; any other code counts as floating
	always_comb begin
		case (s_reg.stable[`SY_CFG_LSB +: 2])
			`SEL_TIED_HIGH: mode = MODE_HIGH;
			`SEL_TIED_LOW:  mode = MODE_LOW;
			default:        mode = MODE_FLOAT;
		endcase
	end

	// status word seen by software
	always_comb begin
		status_w = 32'h0000_0000;
		status_w[`ST_RESET_OUT_FIRST_BIT]  = s_reg.reset_out_first_on;
		status_w[`ST_RESET_OUT_SECOND_BIT]  = s_reg.reset_out_second_on;
		status_w[`ST_FAULT_BIT] = s_reg.fault_on;
		status_w[`ST_WD_RUN_BIT] = s_reg.wd_run;
		status_w[`ST_CH2_EN_BIT] = s_reg.ch2_en;
		status_w[`ST_MODE_LSB +: 2] = mode;
		status_w[`ST_PINS_LSB +: 3] = s_reg.stable[`SY_PIN_LSB +: 3];
	end

	// next-state logic for the whole block
	always_comb begin
		s_next = s_reg;
		fault_hit = 1'b0;
		kick_fall = 1'b0;

		// three-stage synchronisers; a level counts once stages two and three agree
		s_next.sync1 = {watchdog_fault_in, reset_out_second_in, reset_out_first_in,
			seq_select_in, watchdog_disable_in, watchdog_kick_in,
			rail_sense_second_in, rail_sense_first_in};
		s_next.sync2 = s_reg.sync1;
		s_next.sync3 = s_reg.sync2;
		s_next.stable = (s_reg.sync2 & s_reg.sync3) |
			(s_reg.stable & (s_reg.sync2 ^ s_reg.sync3));

		// second channel start order; held while the pin filter fills, since its
		// cleared reset value would otherwise decode as a floating select
		if (s_reg.warm_cnt != `SY_FILL_CYC) begin
			s_next.warm_cnt = s_reg.warm_cnt + 3'd1;
		end else if (mode == MODE_FLOAT) begin
			s_next.ch2_en = 1'b1;
		end else if (rail1_ok) begin
			s_next.ch2_en = 1'b1;
		end

		// release conditions; tied low groups both rails on timer one
		good1 = (mode == MODE_LOW) ? (rail1_ok & rail2_ok) : rail1_ok;
		good2 = rail2_ok;

		// first reset: low rail asserts at once, good rail runs the delay
		if (!good1) begin
			s_next.reset_out_first_on  = 1'b1;
			s_next.por1_cnt = '0;
		end else if (s_reg.reset_out_first_on) begin
			if (s_reg.por1_cnt >= DELAY1_C - ONE_C) begin
				s_next.reset_out_first_on = 1'b0;
			end else begin
				s_next.por1_cnt = s_reg.por1_cnt + ONE_C;
			end
		end

		// second reset: mirrors the first when grouped, else its own rail
		if (mode == MODE_LOW) begin
			s_next.reset_out_second_on  = s_next.reset_out_first_on;
			s_next.por2_cnt = '0;
		end else if (!good2) begin
			s_next.reset_out_second_on  = 1'b1;
			s_next.por2_cnt = '0;
		end else if (s_reg.reset_out_second_on) begin
			if (s_reg.por2_cnt >= DELAY2_C - ONE_C) begin
				s_next.reset_out_second_on = 1'b0;
			end else begin
				s_next.por2_cnt = s_reg.por2_cnt + ONE_C;
			end
		end

		// watchdog start point depends on the sequence
		if (mode == MODE_FLOAT) begin
			wd_start = ~s_reg.reset_out_first_on;
		end else begin
			wd_start = ~s_reg.reset_out_first_on & ~s_reg.reset_out_second_on;
		end
		wd_block = s_reg.stable[`SY_WDOFF] | s_reg.wd_off;

		// window timer; each filtered falling kick edge restarts it
		s_next.kick_prev = kick_lvl;
		if (wd_block || !wd_start) begin
			s_next.wd_run = 1'b0;
			s_next.wd_cnt = '0;
		end else if (!s_reg.wd_run) begin
			s_next.wd_run = 1'b1;
			s_next.wd_cnt = '0;
		end else begin
			kick_fall = s_reg.kick_prev & ~kick_lvl;
			if (kick_fall) begin
				fault_hit = (s_reg.wd_cnt < LOWER_C);
				s_next.wd_cnt = '0;
			end else if (s_reg.wd_cnt >= UPPER_C - ONE_C) begin
				fault_hit = 1'b1;
				s_next.wd_cnt = '0;
			end else begin
				s_next.wd_cnt = s_reg.wd_cnt + ONE_C;
			end
		end

		// fault pulse timer
		if (s_reg.fault_on) begin
			if (s_reg.fault_cnt >= PULSE_C - ONE_C) begin
				s_next.fault_on = 1'b0;
			end else begin
				s_next.fault_cnt = s_reg.fault_cnt + ONE_C;
			end
		end
		// a new violation restarts the pulse
		if (fault_hit) begin
			s_next.fault_on  = 1'b1;
			s_next.fault_cnt = '0;
		end
		// an asserted reset ends the pulse early
		if (s_reg.reset_out_first_on || s_reg.reset_out_second_on) begin
			s_next.fault_on  = 1'b0;
			s_next.fault_cnt = '0;
		end

		// write channel capture, in either order
		if (aw_hit) begin
			s_next.aw_full = 1'b1;
			s_next.aw_addr = axi_awaddr_in;
		end
		if (w_hit) begin
			s_next.w_full = 1'b1;
			s_next.w_data = axi_wdata_in;
			s_next.w_strb = axi_wstrb_in;
		end
		if (s_reg.bvalid && axi_bready_in) begin
			s_next.bvalid = 1'b0;
		end

		// perform a write once both halves are held and no response waits
		if (s_reg.aw_full && s_reg.w_full && !s_reg.bvalid) begin
			s_next.aw_full = 1'b0;
			s_next.w_full  = 1'b0;
			s_next.bvalid  = 1'b1;
			s_next.bresp   = `RESP_OKAY;
			if (s_reg.aw_addr == `ADDR_CTRL) begin
				if (s_reg.w_strb[0]) begin
					s_next.wd_off = s_reg.w_data[`CTRL_WD_OFF_BIT];
				end
			end else if (s_reg.aw_addr == `ADDR_FAULTS) begin
				// a write with byte lane 0 enabled clears the counter; a fault in the same cycle still counts
				if (s_reg.w_strb[0]) begin
					s_next.fault_total = 8'h00;
				end
			end else if (s_reg.aw_addr == `ADDR_STATUS) begin
				s_next.bresp = `RESP_OKAY;
			end else begin
				s_next.bresp = `RESP_SLVERR;
			end
		end
		// counter saturates rather than wrap, so a storm stays visible
		if (fault_hit && (s_next.fault_total != 8'hff)) begin
			s_next.fault_total = s_next.fault_total + 8'h01;
		end

		// read channel: data registered with the valid
		if (s_reg.rvalid && axi_rready_in) begin
			s_next.rvalid = 1'b0;
		end
		if (ar_hit) begin
			s_next.rvalid = 1'b1;
			s_next.rresp  = `RESP_OKAY;
			if (axi_araddr_in == `ADDR_CTRL) begin
				s_next.rdata = {31'h0000_0000, s_reg.wd_off};
			end else if (axi_araddr_in == `ADDR_STATUS) begin
				s_next.rdata = status_w;
			end else if (axi_araddr_in == `ADDR_FAULTS) begin
				s_next.rdata = {24'h00_0000, s_reg.fault_total};
			end else begin
				s_next.rdata = 32'h0000_0000;
				s_next.rresp = `RESP_SLVERR;
			end
		end
	end

	// state register; reset holds both resets asserted and the bus idle
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			s_reg         <= '0;
			s_reg.reset_out_first_on <= 1'b1;
			s_reg.reset_out_second_on <= 1'b1;
			s_reg.wd_off  <= `CTRL_RESET;
		end else begin
			s_reg <= s_next;
		end
	end

endmodule

// ==== supervisor_checker_props.sv ====
// concurrent checks on the supervisor pins and its register bus handshakes
`timescale 1ns/1ps
module supervisor_checker #(
	parameter int RESET_DELAY_FIRST  = 40,
	parameter int RESET_DELAY_SECOND = 40,
	parameter int FAULT_PULSE        = 25
) (
	input wire logic        clk_in,
	input wire logic        resetn_in,
	input wire logic        rail_sense_first_in,
	input wire logic        rail_sense_second_in,
	input wire logic [1:0]  seq_select_in,
	input wire logic        watchdog_disable_in,
	input wire logic        reset_out_first_out,
	input wire logic        reset_out_first_oen_out,
	input wire logic        reset_out_second_out,
	input wire logic        reset_out_second_oen_out,
	input wire logic        watchdog_fault_out,
	input wire logic        watchdog_fault_oen_out,
	input wire logic        channel_second_enable_out,
	input wire logic        axi_awvalid_in,
	input wire logic        axi_awready_out,
	input wire logic        axi_wvalid_in,
	input wire logic        axi_wready_out,
	input wire logic        axi_bvalid_out,
	input wire logic        axi_arvalid_in,
	input wire logic        axi_arready_out,
	input wire logic        axi_rvalid_out
);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!resetn_in);
	int good1_cnt; // unbroken good samples of rail one
	int good2_cnt; // unbroken good samples of rail two
	int low_cnt;   // cycles the fault pin has been pulled so far
	// counters restart on any break so they measure unbroken stretches only
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			good1_cnt <= 0;
			good2_cnt <= 0;
			low_cnt <= 0;
		end else begin
			good1_cnt <= rail_sense_first_in ? good1_cnt + 1 : 0;
			good2_cnt <= rail_sense_second_in ? good2_cnt + 1 : 0;
			low_cnt <= watchdog_fault_oen_out ? 0 : low_cnt + 1;
		end
	end
	uv_first_a: assert property (!rail_sense_first_in [*6] |-> !reset_out_first_oen_out)
		else $error("first reset not pulled on low rail");
	uv_second_a: assert property (!rail_sense_second_in [*6] |-> !reset_out_second_oen_out)
		else $error("second reset not pulled on low rail");
	release_first_a: assert property ($rose(reset_out_first_oen_out)
		|-> good1_cnt >= RESET_DELAY_FIRST) else $error("first reset released early");
	release_second_a: assert property ($rose(reset_out_second_oen_out) && seq_select_in != 2'b10
		|-> good2_cnt >= RESET_DELAY_SECOND) else $error("second reset released early");
	open_drain_a: assert property (!reset_out_first_out && !reset_out_second_out
		&& !watchdog_fault_out) else $error("open drain data not low");
	ch2_hold_a: assert property ($rose(channel_second_enable_out) && seq_select_in inside {2'b01, 2'b10}
		|-> good1_cnt >= 2) else $error("second channel started before rail one");
	wd_off_a: assert property (watchdog_disable_in [*6] ##0 watchdog_fault_oen_out
		|=> watchdog_fault_oen_out) else $error("fault while watchdog disabled");
	pulse_len_a: assert property ($rose(watchdog_fault_oen_out) |-> (low_cnt >= FAULT_PULSE - 1
		&& low_cnt <= FAULT_PULSE + 1) || !reset_out_first_oen_out || !reset_out_second_oen_out)
		else $error("fault pulse length wrong");
	fault_cut_a: assert property ($fell(reset_out_first_oen_out) || $fell(reset_out_second_oen_out)
		|-> ##[0:3] watchdog_fault_oen_out) else $error("fault not ended by reset");
	wr_resp_a: assert property (axi_awvalid_in && axi_awready_out && axi_wvalid_in && axi_wready_out
		&& !axi_bvalid_out |-> ##2 axi_bvalid_out) else $error("write response late");
	rd_refuse_a: assert property (axi_rvalid_out |-> !axi_arready_out)
		else $error("read address taken while answer pending");
endmodule

bind supervisor_reset_watchdog supervisor_checker #(.RESET_DELAY_FIRST(RESET_DELAY_FIRST),
	.RESET_DELAY_SECOND(RESET_DELAY_SECOND), .FAULT_PULSE(FAULT_PULSE)) u_supervisor_checker (
	.clk_in, .resetn_in, .rail_sense_first_in, .rail_sense_second_in, .seq_select_in,
	.watchdog_disable_in, .reset_out_first_out, .reset_out_first_oen_out, .reset_out_second_out,
	.reset_out_second_oen_out, .watchdog_fault_out, .watchdog_fault_oen_out,
	.channel_second_enable_out, .axi_awvalid_in, .axi_awready_out, .axi_wvalid_in,
	.axi_wready_out, .axi_bvalid_out, .axi_arvalid_in, .axi_arready_out, .axi_rvalid_out);

// ==== host_kick_model.sv ====
// host model: falling edges on the kick line at a programmable spacing
`timescale 1ns/1ps
module host_kick_model (
	input  wire logic        clk_in,
	input  wire logic        resetn_in,
	input  wire logic        run_in,
	input  wire logic [15:0] period_in,
	output logic             kick_out
);
	logic [15:0] cnt_reg; // position inside the current kick period
	// starting at one puts the first edge one cycle short of half a period after run rises
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			cnt_reg <= 16'h0001;
		end else if (!run_in) begin
			cnt_reg <= 16'h0001;
		end else if (cnt_reg >= period_in - 16'h0001) begin
			cnt_reg <= 16'h0000;
		end else begin
			cnt_reg <= cnt_reg + 16'h0001;
		end
	end
	// idle host leaves the line to its pull-up; edge falls mid-period
	assign kick_out = !run_in || (cnt_reg < (period_in >> 1));
endmodule

// ==== supervisor_reset_watchdog_tb_top.sv ====
// testbench: reset sequencing, window watchdog and register access
`timescale 1ns/1ps
module supervisor_reset_watchdog_tb_top;
	localparam int D1 = 40, D2 = 60, WU = 200, WL = 20, FP = 25; // shortened counts
	logic clk_in = 1'b0, resetn_in = 1'b0, rail_sense_first_in = 1'b0, rail_sense_second_in = 1'b0;
	logic [1:0] seq_select_in = 2'b01;
	logic watchdog_disable_in = 1'b0, host_run = 1'b0, watchdog_kick_in;
	logic [15:0] host_period = 16'd50;
	logic [3:0] axi_awaddr_in = 4'h0, axi_araddr_in = 4'h0, axi_wstrb_in = 4'hf;
	logic [31:0] axi_wdata_in = 32'h0, axi_rdata_out;
	logic axi_awvalid_in = 1'b0, axi_wvalid_in = 1'b0, axi_bready_in = 1'b0;
	logic axi_arvalid_in = 1'b0, axi_rready_in = 1'b0;
	logic axi_awready_out, axi_wready_out, axi_bvalid_out, axi_arready_out, axi_rvalid_out;
	logic [1:0] axi_bresp_out, axi_rresp_out;
	logic reset_out_first_out, reset_out_first_oen_out, reset_out_second_out;
	logic reset_out_second_oen_out, watchdog_fault_out, watchdog_fault_oen_out;
	logic channel_second_enable_out;
	int n_fail = 0, cmp_count = 0;
	// open-drain wires: pull-up wins unless a driver is enabled
	wire reset_out_first_in = reset_out_first_oen_out ? 1'b1 : reset_out_first_out;
	wire reset_out_second_in = reset_out_second_oen_out ? 1'b1 : reset_out_second_out;
	wire watchdog_fault_in = watchdog_fault_oen_out ? 1'b1 : watchdog_fault_out;
	supervisor_reset_watchdog #(.RESET_DELAY_FIRST(D1), .RESET_DELAY_SECOND(D2),
		.WIN_UPPER(WU), .WIN_LOWER(WL), .FAULT_PULSE(FP)) u_supervisor_reset_watchdog (.*);
	host_kick_model u_host_kick_model (.clk_in, .resetn_in, .run_in(host_run),
		.period_in(host_period), .kick_out(watchdog_kick_in));
	// free-running system clock
	initial begin
		forever #10 clk_in = ~clk_in;
	end
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask
	// a wait that runs out is a mismatch and ends the run
	task automatic bail();
		chk(32'h0, 32'h1);
		test_done();
	endtask
	function automatic logic pin(input int i);
		case (i)
			0: return reset_out_first_oen_out;
			1: return reset_out_second_oen_out;
			2: return watchdog_fault_oen_out;
			default: return channel_second_enable_out;
		endcase
	endfunction
	// counts edges until a pin shows the wanted level
	task automatic wt(input int i, input logic v, input int lim, output int n);
		n = 0;
		while (pin(i) !== v) begin
			@(posedge clk_in);
			n++;
			if (n > lim) bail();
		end
	endtask
	// the pin must keep its level for len cycles
	task automatic hold(input int i, input logic v, input int len);
		int k;
		for (k = 0; k < len && pin(i) === v; k++) @(posedge clk_in);
		chk(k, len);
	endtask
	// bus write: address and data offered together, bready held until bvalid
	task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
		int k;
		@(posedge clk_in);
		axi_awaddr_in <= a;
		axi_wdata_in <= d;
		axi_awvalid_in <= 1'b1;
		axi_wvalid_in <= 1'b1;
		axi_bready_in <= 1'b1;
		for (k = 0; k < 50; k++) begin
			@(posedge clk_in);
			if (axi_awvalid_in && axi_awready_out) axi_awvalid_in <= 1'b0;
			if (axi_wvalid_in && axi_wready_out) axi_wvalid_in <= 1'b0;
			if (axi_bvalid_out) break;
		end
		if (k == 50) bail();
		axi_bready_in <= 1'b0;
		chk(axi_bresp_out, er);
	endtask
	// bus read, compared under a mask
	task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e,
		input logic [1:0] er);
		int k;
		@(posedge clk_in);
		axi_araddr_in <= a;
		axi_arvalid_in <= 1'b1;
		axi_rready_in <= 1'b1;
		for (k = 0; k < 50; k++) begin
			@(posedge clk_in);
			if (axi_arvalid_in && axi_arready_out) axi_arvalid_in <= 1'b0;
			if (axi_rvalid_out) break;
		end
		if (k == 50) bail();
		axi_rready_in <= 1'b0;
		chk(axi_rdata_out & m, e);
		chk(axi_rresp_out, er);
	endtask
	task automatic restart(input logic [1:0] s);
		@(posedge clk_in);
		resetn_in <= 1'b0;
		seq_select_in <= s;
		rail_sense_first_in <= 1'b0;
		rail_sense_second_in <= 1'b0;
		host_run <= 1'b0;
		repeat (6) @(posedge clk_in);
		resetn_in <= 1'b1;
		repeat (6) @(posedge clk_in);
	endtask
	initial begin
		int n, m;
		restart(2'b01);
		chk({reset_out_first_oen_out, reset_out_second_oen_out, watchdog_fault_oen_out,
			channel_second_enable_out}, 4'b0010);
		rd(4'h4, 32'h3ff, 32'h223, 2'b00);
		rail_sense_first_in <= 1'b1;
		wt(3, 1'b1, 10, n);
		wt(0, 1'b1, D1 + 20, m);
		chk(n + m >= D1 && n + m <= D1 + 8, 1'b1);
		chk(reset_out_second_oen_out, 1'b0);
		rd(4'h4, 32'h8, 32'h0, 2'b00);
		rail_sense_second_in <= 1'b1;
		wt(1, 1'b1, D2 + 20, n);
		chk(n >= D2 && n <= D2 + 8, 1'b1);
		host_run <= 1'b1;
		hold(2, 1'b1, 600);
		rd(4'h4, 32'h8, 32'h8, 2'b00);
		rd(4'h8, 32'hff, 32'h0, 2'b00);
		host_period <= 16'd10;
		wt(2, 1'b0, 40, n);
		host_run <= 1'b0;
		wt(2, 1'b1, FP + 5, n);
		wt(2, 1'b0, WU + 20, m);
		chk(n >= FP - 1 && n <= FP + 1, 1'b1);
		chk(n + m >= WU - 2 && n + m <= WU + 4, 1'b1);
		wt(2, 1'b1, FP + 5, n);
		watchdog_disable_in <= 1'b1;
		rd(4'h8, 32'hff, 32'h2, 2'b00);
		wr(4'h8, 32'h0, 2'b00);
		rd(4'h8, 32'hff, 32'h0, 2'b00);
		wr(4'h4, 32'hffff_ffff, 2'b00);
		rd(4'hc, 32'hffff_ffff, 32'h0, 2'b10);
		wr(4'hc, 32'h1, 2'b10);
		wr(4'h0, 32'h1, 2'b00);
		rd(4'h0, 32'h1, 32'h1, 2'b00);
		wr(4'h0, 32'h0, 2'b00);
		hold(2, 1'b1, 3 * WU);
		watchdog_disable_in <= 1'b0;
		wt(2, 1'b0, WU + 20, n);
		rail_sense_second_in <= 1'b0;
		wt(1, 1'b0, 8, n);
		wt(2, 1'b1, 4, n);
		restart(2'b10);
		rail_sense_second_in <= 1'b1;
		hold(1, 1'b0, 100);
		chk(channel_second_enable_out, 1'b0);
		rail_sense_first_in <= 1'b1;
		wt(0, 1'b1, D2 + 20, n);
		chk(n >= D1 && n <= D1 + 8, 1'b1);
		wt(1, 1'b1, 2, m);
		restart(2'b00);
		wt(3, 1'b1, 10, n);
		rail_sense_first_in <= 1'b1;
		wt(0, 1'b1, D1 + 20, n);
		repeat (4) @(posedge clk_in);
		rd(4'h4, 32'h8, 32'h8, 2'b00);
		chk(reset_out_second_oen_out, 1'b0);
		for (n = 0; n < 4; n++) begin
			seq_select_in <= n[1:0];
			repeat (5) @(posedge clk_in);
			rd(4'h4, 32'h60, n == 1 ? 32'h20 : n == 2 ? 32'h40 : 32'h0, 2'b00);
		end
		test_done();
	end
endmodule
